/* File: dac_ctrl_pkg.sv */
// Constants, types and register map of the converter control block.
// Assumes a register port already decoded from the serial interface.
package dac_ctrl_pkg;

    // Register offsets
    localparam logic [7:0] OFS_PWR = 8'h00;
    localparam logic [7:0] OFS_CLK = 8'h02;
    localparam logic [7:0] OFS_DIV = 8'h0E;
    localparam logic [7:0] OFS_CAL = 8'h0F;
    localparam logic [7:0] OFS_IDX = 8'h10;
    localparam logic [7:0] OFS_VAL = 8'h11;

    // Field positions
    localparam int PWR_CLK_OFF_BIT = 1;
    localparam int PWR_SLEEP_BIT = 2;
    localparam int PWR_FULL_BIT = 3;
    localparam int CLK_CAL_EN_BIT = 0;
    localparam int CLK_DIFF_BIT = 2;
    localparam int CAL_RD_BIT = 2;
    localparam int CAL_WR_BIT = 3;
    localparam int CAL_START_BIT = 6;
    localparam int CAL_DONE_BIT = 7;

    // Writable bits per register, the rest read as zero apart from the calibration done bit
    localparam logic [7:0] PWR_MASK = 8'h0E;
    localparam logic [7:0] CLK_MASK = 8'h05;
    localparam logic [7:0] DIV_MASK = 8'h07;
    localparam logic [7:0] CAL_MASK = 8'h4C;
    localparam logic [7:0] REG_RESET = 8'h00;

    // Coefficient store
    localparam int NUM_COEF = 33;
    localparam logic [7:0] COEF_LAST = 8'h20;

    // Divider base: a select of n divides by 2 << n
    localparam logic [8:0] DIV_BASE = 9'h002;

    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int PD_TIME_NS = 50;
    localparam int WAKE_TIME_NS = 5000;
    localparam int PD_CYCLES = (PD_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : PD_TIME_NS / CLK_PERIOD_NS;
    localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAL_TICKS_DEF = 4500;

    typedef enum logic [2:0] {
        CAL_IDLE = 3'b001,
        CAL_RUN = 3'b010,
        CAL_DONE = 3'b100
    } cal_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic current_on;
        logic bandgap_on;
        logic conv_clock_on;
        logic diff_rx_on;
    } analog_ctl_t;

endpackage

/* File: dac_power_cal_ctrl.sv */
// Power-down, clock mode, self-calibration and coefficient store of a DAC.
// Assumes register requests arrive one per cycle, synchronous to CLOCK.
`timescale 1ns/10ps

// Summary of operation
// - Input data is captured on the rising clock edge.
// - In pin mode a high sleep pin turns off output current.
// - An undriven sleep pin reads low, so sleep is not entered.
// - Power-down completes within 50 ns; recovery takes about 5 us.
// - Serial power bits 1..3 select clock-off, sleep and full power-down.
// - A serial power-down function is active while its bit is one.
// - Full power-down turns off output current and bandgap.
// - Calibration clock is the DAC clock divided by 2 << select field.
// - Divider select occupies bits 2..0 of the divider register.
// - One calibration clock spans 2 to 256 DAC clocks.
// - Calibration clock runs only while its enable bit is set.
// - Writing 0x40 to calibration control starts a calibration.
// - A calibration takes about 4500 calibration clocks.
// - Bit 7 of calibration control reads one when done.
// - Thirty-three coefficients can be read and overwritten.
// - Read: set index, set read bit, read data, clear control.
// - Write: set write bit, write index and value, clear control.
// - Differential receiver is off in single-ended clock mode.
// - Clock control bit 2 selects differential clock in serial mode.
module dac_power_cal_ctrl #(
    parameter int DATA_W = 14,
    parameter int CAL_TICKS = dac_ctrl_pkg::CAL_TICKS_DEF
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESET_N,
    // Register port
    input wire dac_ctrl_pkg::reg_req_t REG_REQ,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    // Mode pins
    input wire logic SERIAL_MODE,
    input wire logic SLEEP_PIN,
    input wire logic SLEEP_PIN_DRIVEN,
    input wire logic CMODE_PIN,
    // Converter data
    input wire logic [DATA_W-1:0] DATA_IN,
    output logic [DATA_W-1:0] DAC_CODE,
    // Calibration front end
    input wire logic [7:0] CAL_MEAS,
    output logic CAL_TICK,
    output logic CAL_BUSY,
    // Analog controls
    output dac_ctrl_pkg::analog_ctl_t ANALOG_CTL,
    output logic POWER_READY
);
    import dac_ctrl_pkg::*;

    logic [7:0] pwr_r;
    logic [7:0] clkc_r;
    logic [7:0] div_r;
    logic [7:0] cal_r;
    logic [7:0] idx_r;
    logic [7:0] val_r;
    logic [7:0] coef_mem [NUM_COEF];
    cal_state_t state_r;
    cal_state_t state_nxt;
    logic [7:0] div_cnt_r;
    logic [12:0] tick_cnt_r;
    logic [7:0] wake_cnt_r;

    logic wr_pwr;
    logic wr_clk;
    logic wr_div;
    logic wr_cal;
    logic wr_idx;
    logic wr_val;
    logic cal_en;
    logic idx_ok;
    logic coef_rd_ok;
    logic coef_wr_ok;
    logic [8:0] div_n;
    logic div_wrap;
    logic cal_last;
    logic pin_sleep;
    logic current_off;
    logic [7:0] cal_rd;

    assign wr_pwr = REG_REQ.wr && REG_REQ.addr == OFS_PWR;
    assign wr_clk = REG_REQ.wr && REG_REQ.addr == OFS_CLK;
    assign wr_div = REG_REQ.wr && REG_REQ.addr == OFS_DIV;
    assign wr_cal = REG_REQ.wr && REG_REQ.addr == OFS_CAL;
    assign wr_idx = REG_REQ.wr && REG_REQ.addr == OFS_IDX;
    assign wr_val = REG_REQ.wr && REG_REQ.addr == OFS_VAL;

    assign cal_en = clkc_r[CLK_CAL_EN_BIT];
    assign idx_ok = idx_r <= COEF_LAST;
    assign coef_rd_ok = cal_en && cal_r[CAL_RD_BIT] && idx_ok;
    // Host writes are locked out while the engine owns the store
    assign coef_wr_ok = wr_val && cal_en && cal_r[CAL_WR_BIT] && idx_ok && state_r != CAL_RUN;

    // Register writes
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            pwr_r <= REG_RESET;
            clkc_r <= REG_RESET;
            div_r <= REG_RESET;
            cal_r <= REG_RESET;
            idx_r <= REG_RESET;
            val_r <= REG_RESET;
        end else begin
            if (wr_pwr) begin
                pwr_r <= REG_REQ.wdata & PWR_MASK;
            end
            if (wr_clk) begin
                clkc_r <= REG_REQ.wdata & CLK_MASK;
            end
            if (wr_div) begin
                div_r <= REG_REQ.wdata & DIV_MASK;
            end
            if (wr_cal) begin
                cal_r <= REG_REQ.wdata & CAL_MASK;
            end
            if (wr_idx) begin
                idx_r <= REG_REQ.wdata;
            end
            if (wr_val) begin
                val_r <= REG_REQ.wdata;
            end
        end
    end

    // Calibration clock divider
    assign div_n = DIV_BASE << div_r[2:0];
    assign div_wrap = div_cnt_r == 8'(div_n - 9'h001);

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            div_cnt_r <= 8'h00;
            CAL_TICK <= 1'b0;
        end else if (!cal_en) begin
            div_cnt_r <= 8'h00;
            CAL_TICK <= 1'b0;
        end else begin
            div_cnt_r <= div_wrap ? 8'h00 : div_cnt_r + 8'h01;
            CAL_TICK <= div_wrap;
        end
    end

    // Calibration sequencer
    assign cal_last = CAL_TICK && tick_cnt_r == 13'(CAL_TICKS - 1);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CAL_IDLE: begin
                if (cal_r[CAL_START_BIT]) begin
                    state_nxt = CAL_RUN;
                end
            end
            CAL_RUN: begin
                // Completion wins over a clear arriving in the same cycle
                if (cal_last) begin
                    state_nxt = CAL_DONE;
                end else if (!cal_r[CAL_START_BIT]) begin
                    state_nxt = CAL_IDLE;
                end
            end
            CAL_DONE: begin
                if (wr_cal && !REG_REQ.wdata[CAL_START_BIT]) begin
                    state_nxt = CAL_IDLE;
                end else if (wr_cal) begin
                    state_nxt = CAL_RUN;
                end
            end
            default: begin
                state_nxt = CAL_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            state_r <= CAL_IDLE;
            CAL_BUSY <= 1'b0;
        end else begin
            state_r <= state_nxt;
            CAL_BUSY <= state_nxt == CAL_RUN;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            tick_cnt_r <= 13'h0000;
        end else if (state_r != CAL_RUN) begin
            tick_cnt_r <= 13'h0000;
        end else if (CAL_TICK) begin
            tick_cnt_r <= tick_cnt_r + 13'h0001;
        end
    end

    // Coefficient store: engine fills it early in a run, host may overwrite later
    always_ff @(posedge CLOCK) begin
        if (state_r == CAL_RUN && CAL_TICK && tick_cnt_r < 13'(NUM_COEF)) begin
            coef_mem[tick_cnt_r[5:0]] <= CAL_MEAS;
        end else if (coef_wr_ok) begin
            coef_mem[idx_r[5:0]] <= REG_REQ.wdata;
        end
    end

    // Register reads, answered one cycle after the request
    assign cal_rd = cal_r | {state_r == CAL_DONE, 7'h00};

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            REG_RDATA <= 8'h00;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_REQ.rd;
            if (REG_REQ.rd) begin
                case (REG_REQ.addr)
                    OFS_PWR: REG_RDATA <= pwr_r;
                    OFS_CLK: REG_RDATA <= clkc_r;
                    OFS_DIV: REG_RDATA <= div_r;
                    OFS_CAL: REG_RDATA <= cal_rd;
                    OFS_IDX: REG_RDATA <= idx_r;
                    OFS_VAL: REG_RDATA <= coef_rd_ok ? coef_mem[idx_r[5:0]] : val_r;
                    default: REG_RDATA <= 8'h00;
                endcase
            end
        end
    end

    // Power control
    // An undriven pin is forced low, standing in for the on-chip pull-down
    assign pin_sleep = !SERIAL_MODE && SLEEP_PIN && SLEEP_PIN_DRIVEN;
    assign current_off = pin_sleep
        || (SERIAL_MODE && (pwr_r[PWR_SLEEP_BIT] || pwr_r[PWR_FULL_BIT]));

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            ANALOG_CTL <= '0;
        end else begin
            ANALOG_CTL.current_on <= !current_off;
            ANALOG_CTL.bandgap_on <= !(SERIAL_MODE && pwr_r[PWR_FULL_BIT]);
            ANALOG_CTL.conv_clock_on <= !(SERIAL_MODE && pwr_r[PWR_CLK_OFF_BIT]);
            ANALOG_CTL.diff_rx_on <= SERIAL_MODE ? clkc_r[CLK_DIFF_BIT] : CMODE_PIN;
        end
    end

    // Recovery timer: full operation only after the wake time has elapsed
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            wake_cnt_r <= 8'(WAKE_CYCLES);
            POWER_READY <= 1'b0;
        end else if (current_off) begin
            wake_cnt_r <= 8'(WAKE_CYCLES);
            POWER_READY <= 1'b0;
        end else if (wake_cnt_r != 8'h00) begin
            wake_cnt_r <= wake_cnt_r - 8'h01;
            POWER_READY <= 1'b0;
        end else begin
            POWER_READY <= 1'b1;
        end
    end

    // Data capture, frozen while the converter clock is off
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            DAC_CODE <= '0;
        end else if (ANALOG_CTL.conv_clock_on) begin
            DAC_CODE <= DATA_IN;
        end
    end

    // Helper: cycles since output current was last off
    logic [7:0] on_age_h;
    always_ff @(posedge CLOCK) begin
        if (!RESET_N || current_off) begin
            on_age_h <= 8'h00;
        end else if (on_age_h != 8'hFF) begin
            on_age_h <= on_age_h + 8'h01;
        end
    end

    property p_capture;
        @(posedge CLOCK) disable iff (!RESET_N)
        ANALOG_CTL.conv_clock_on |=> DAC_CODE == $past(DATA_IN);
    endproperty
    a_capture: assert property (p_capture) else $error("data not captured");

    property p_pin_sleep;
        @(posedge CLOCK) disable iff (!RESET_N)
        pin_sleep |-> ##1 !ANALOG_CTL.current_on;
    endproperty
    a_pin_sleep: assert property (p_pin_sleep) else $error("pin sleep ignored");

    property p_pulldown;
        @(posedge CLOCK) disable iff (!RESET_N)
        (!SERIAL_MODE && !SLEEP_PIN_DRIVEN) |=> ANALOG_CTL.current_on;
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("floating pin slept");

    property p_wake;
        @(posedge CLOCK) disable iff (!RESET_N)
        POWER_READY |-> on_age_h > 8'(WAKE_CYCLES);
    endproperty
    a_wake: assert property (p_wake) else $error("ready too early");

    property p_full_pd;
        @(posedge CLOCK) disable iff (!RESET_N)
        (SERIAL_MODE && pwr_r[PWR_FULL_BIT]) |=> !ANALOG_CTL.bandgap_on && !ANALOG_CTL.current_on;
    endproperty
    a_full_pd: assert property (p_full_pd) else $error("full power-down late");

    property p_tick;
        @(posedge CLOCK) disable iff (!RESET_N)
        CAL_TICK |-> $past(cal_en) ##1 !CAL_TICK;
    endproperty
    a_tick: assert property (p_tick) else $error("bad calibration tick");

    property p_start;
        @(posedge CLOCK) disable iff (!RESET_N)
        (state_r == CAL_IDLE && wr_cal && REG_REQ.wdata[CAL_START_BIT]) |=> ##1 CAL_BUSY;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_done_low;
        @(posedge CLOCK) disable iff (!RESET_N)
        (REG_REQ.rd && REG_REQ.addr == OFS_CAL && state_r != CAL_DONE) |=> !REG_RDATA[CAL_DONE_BIT];
    endproperty
    a_done_low: assert property (p_done_low) else $error("done shown early");

    property p_coef_wr;
        @(posedge CLOCK) disable iff (!RESET_N)
        coef_wr_ok |=> coef_mem[$past(idx_r[5:0])] == $past(REG_REQ.wdata);
    endproperty
    a_coef_wr: assert property (p_coef_wr) else $error("coefficient not stored");

    property p_diff;
        @(posedge CLOCK) disable iff (!RESET_N)
        (SERIAL_MODE && !clkc_r[CLK_DIFF_BIT]) |=> !ANALOG_CTL.diff_rx_on;
    endproperty
    a_diff: assert property (p_diff) else $error("receiver left on");

endmodule

/* File: dac_host_model.sv */
// Host model: register port master and converter data source.
// Assumes the bench calls its tasks one at a time from one process.
`timescale 1ns/10ps
module dac_host_model (
    // Clock
    input wire logic clock,
    // Register port
    output dac_ctrl_pkg::reg_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    // Converter data
    output logic [13:0] data
);
    import dac_ctrl_pkg::*;

    initial begin
        req = '0;
    end

    // Data moves on the falling edge, clear of the sampling edge
    initial begin
        data = 14'h0000;
        forever begin
            @(negedge clock);
            data <= data + 14'h0123;
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        #1;
        req = '0;
    endtask

    // Read data is only trusted while the valid pulse stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        #1;
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        #1;
        req = '0;
        d = (rvalid === 1'b1) ? rdata : 8'hXX;
    endtask
endmodule

/* File: dac_power_and_self_cal_ctrl_test.sv */
// Self-checking bench of the converter control block.
// Assumes the package and the host model are compiled before it.
`timescale 1ns/10ps
module dac_power_and_self_cal_ctrl_test;
    import dac_ctrl_pkg::*;
    // Short run, still long enough to fill every coefficient
    localparam int TICKS = 40;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic serial = 1'b1;
    logic sleep = 1'b0;
    logic driven = 1'b1;
    logic cmode = 1'b0;
    logic [7:0] meas = 8'h5A;
    reg_req_t req;
    logic [7:0] rdata;
    logic rvalid;
    logic [13:0] data;
    logic [13:0] code;
    logic tick;
    logic busy;
    analog_ctl_t actl;
    logic pready;
    int n_errors = 0;
    int n_checks = 0;

    always #20 clock = ~clock;

    dac_host_model host_u (.clock(clock), .req(req), .rdata(rdata), .rvalid(rvalid), .data(data));
    dac_power_cal_ctrl #(.DATA_W(14), .CAL_TICKS(TICKS)) dut_u (
        .CLOCK(clock), .RESET_N(reset_n), .REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid),
        .SERIAL_MODE(serial), .SLEEP_PIN(sleep), .SLEEP_PIN_DRIVEN(driven), .CMODE_PIN(cmode),
        .DATA_IN(data), .DAC_CODE(code), .CAL_MEAS(meas), .CAL_TICK(tick), .CAL_BUSY(busy),
        .ANALOG_CTL(actl), .POWER_READY(pready));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic step(inout int n);
        cyc(1);
        n++;
    endtask

    task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_u.rd(a, d);
        chk(name, d, exp);
    endtask

    // Cycles from one calibration tick to the next
    task automatic gap(output int n);
        n = 0;
        while (tick !== 1'b1 && n < 600) step(n);
        n = 0;
        do step(n); while (tick !== 1'b1 && n < 600);
    endtask

    task automatic t_reset();
        logic [7:0] ofs [7] = '{OFS_PWR, OFS_CLK, OFS_DIV, OFS_CAL, OFS_IDX, OFS_VAL, 8'h05};
        foreach (ofs[i]) rdchk("reset value", ofs[i], REG_RESET);
        chk("analog after reset", actl, 4'b1110);
        chk("ready after wake", pready, 1'b1);
    endtask

    task automatic t_regs();
        host_u.wr(OFS_CLK, 8'hFF);
        rdchk("clock control", OFS_CLK, CLK_MASK);
        chk("diff receiver on", actl.diff_rx_on, 1'b1);
        host_u.wr(OFS_DIV, 8'hFF);
        rdchk("divider", OFS_DIV, 8'h07);
        host_u.wr(OFS_CLK, 8'h00);
        cyc(1);
        chk("diff receiver off", actl.diff_rx_on, 1'b0);
        host_u.wr(8'h05, 8'hFF);
        rdchk("unmapped", 8'h05, 8'h00);
    endtask

    task automatic t_power();
        logic [7:0] pw [3] = '{8'h02, 8'h04, 8'h08};
        logic [3:0] ex [3] = '{4'b1100, 4'b0110, 4'b0010};
        logic [13:0] held;
        chk("data capture", code, data);
        for (int i = 0; i < 3; i++) begin
            host_u.wr(OFS_PWR, pw[i]);
            cyc(1);
            chk("analog controls", actl, ex[i]);
            held = code;
            cyc(2);
            chk("code", code, i == 0 ? held : data);
        end
        host_u.wr(OFS_PWR, 8'h00);
        cyc(1);
        chk("analog restored", actl, 4'b1110);
        cyc(118);
        chk("ready during wake", pready, 1'b0);
        cyc(10);
        chk("ready after wake", pready, 1'b1);
    endtask

    task automatic t_pin();
        serial = 1'b0;
        sleep = 1'b1;
        host_u.wr(OFS_PWR, 8'h08);
        cyc(1);
        chk("pin sleep", actl, 4'b0110);
        // Pad level left high so that only the pull-down can keep sleep off
        driven = 1'b0;
        cmode = 1'b1;
        cyc(2);
        chk("floating pin", actl, 4'b1111);
        host_u.wr(OFS_PWR, 8'h00);
        serial = 1'b1;
        sleep = 1'b0;
        driven = 1'b1;
        cmode = 1'b0;
        cyc(130);
        chk("awake", pready, 1'b1);
    endtask

    task automatic t_cal();
        int n;
        host_u.wr(OFS_DIV, 8'h01);
        host_u.wr(OFS_CLK, 8'h01);
        host_u.wr(OFS_CAL, 8'h40);
        n = 0;
        while (busy !== 1'b1 && n < 4) step(n);
        chk("busy after start", busy, 1'b1);
        rdchk("running status", OFS_CAL, 8'h40);
        n = 2;
        while (busy === 1'b1 && n < TICKS * 8) step(n);
        chk("run length", n >= TICKS * 4 - 8 && n <= TICKS * 4 + 8, 1'b1);
        rdchk("done status", OFS_CAL, 8'hC0);
        // A start written while done restarts straight away
        host_u.wr(OFS_CAL, 8'h40);
        chk("restart from done", busy, 1'b1);
        rdchk("restarted status", OFS_CAL, 8'h40);
        n = 0;
        while (busy === 1'b1 && n < TICKS * 8) step(n);
        rdchk("done again", OFS_CAL, 8'hC0);
        host_u.wr(OFS_CAL, 8'h00);
        rdchk("cleared status", OFS_CAL, 8'h00);
        host_u.wr(OFS_DIV, 8'h07);
        host_u.wr(OFS_CAL, 8'h40);
        gap(n);
        chk("slowest cal clock", n, 256);
        host_u.wr(OFS_CLK, 8'h00);
        cyc(2);
        n = 0;
        repeat (300) begin
            cyc(1);
            if (tick !== 1'b0) n++;
        end
        chk("ticks while gated", n, 0);
        host_u.wr(OFS_CAL, 8'h00);
        cyc(2);
        chk("abort", busy, 1'b0);
    endtask

    task automatic t_coef();
        host_u.wr(OFS_CLK, 8'h01);
        host_u.wr(OFS_IDX, 8'h00);
        host_u.wr(OFS_CAL, 8'h04);
        rdchk("measured coefficient", OFS_VAL, 8'h5A);
        host_u.wr(OFS_CAL, 8'h08);
        for (int k = 0; k < NUM_COEF; k++) begin
            host_u.wr(OFS_IDX, 8'(k));
            host_u.wr(OFS_VAL, 8'(k * 7 + 3));
        end
        host_u.wr(OFS_CAL, 8'h00);
        for (int k = 0; k < NUM_COEF; k++) begin
            host_u.wr(OFS_IDX, 8'(k));
            host_u.wr(OFS_CAL, 8'h04);
            rdchk("coefficient", OFS_VAL, 8'(k * 7 + 3));
            host_u.wr(OFS_CAL, 8'h00);
        end
        host_u.wr(OFS_CLK, 8'h00);
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        cyc(5);
        reset_n = 1'b1;
        cyc(130);
        t_reset();
        t_regs();
        t_power();
        t_pin();
        t_cal();
        t_coef();
        complete_run();
    end

    // The whole run needs about 2000 cycles
    initial begin
        cyc(20000);
        n_errors++;
        complete_run();
    end
endmodule
